// *** src/supervisor_regs.svh ***
// Timing constants and widths for the multi-rail reset supervisor.
// Assumes a single 20 MHz system clock; all counts derive from it.
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------------
// Clock and counter widths
// ----------------------------------------------------------------------
`define CLK_HZ        64'd20000000
`define CNT_W         26
`define MD_W          16

// ----------------------------------------------------------------------
// Times in their natural units
// ----------------------------------------------------------------------
`define RP_DEF_MS     64'd140
`define RP_MAX_MS     64'd1120
`define WD_TYP_MS     64'd1600
`define MD_US         64'd100
`define DB_US         64'd100

// ----------------------------------------------------------------------
// Derived cycle counts (least times round up, longest round down)
// ----------------------------------------------------------------------
`define RP_DEF_CYC    ((`RP_DEF_MS * `CLK_HZ + 64'd999) / 64'd1000)
`define RP_MAX_CYC    ((`RP_MAX_MS * `CLK_HZ) / 64'd1000)
`define WD_CYC        ((`WD_TYP_MS * `CLK_HZ) / 64'd1000)
`define MD_CYC        ((`MD_US * `CLK_HZ + 64'd999999) / 64'd1000000)
`define DB_CYC        ((`DB_US * `CLK_HZ + 64'd999999) / 64'd1000000)

`endif

// *** src/supervisor_pkg.sv ***
// Types shared by the supervisor design files.
// Assumes nothing beyond a SystemVerilog compiler.
package supervisor_pkg;

  // ----------------------------------------------------------------------
  // Reset sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [3:0]
  {
    ST_LOCKOUT = 4'h1,  // Supply below lockout, outputs asserted.
    ST_HOLD    = 4'h2,  // A rail is low or manual reset is held.
    ST_TIMEOUT = 4'h4,  // Causes gone, timing the reset period.
    ST_RUN     = 4'h8   // Reset released, watchdog may run.
  } sup_state_t;

endpackage

// *** src/input_sync3.sv ***
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static relative to the 50 ns clock.
`timescale 1ns/10ps
`default_nettype none

module input_sync3
#(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Pins and synchronised levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [W-1:0] s1;   // First stage, read only by the second.
    logic [W-1:0] s2;   // Second stage.
    logic [W-1:0] s3;   // Third stage.
    logic [W-1:0] val;  // Accepted level.
  } sync_regs_t;

  sync_regs_t s_ff;
  sync_regs_t nxt_s;

  // A bit goes high only when stages two and three agree and clears while
  // they differ, which rejects a single high sample caught mid-transition.
  always_comb
  begin
    nxt_s     = s_ff;
    nxt_s.s1  = pin_in;
    nxt_s.s2  = s_ff.s1;
    nxt_s.s3  = s_ff.s2;
    nxt_s.val = (s_ff.val & ~(s_ff.s2 ^ s_ff.s3))
              | (s_ff.s3 & ~(s_ff.s2 ^ s_ff.s3));
  end

  // Synchronous reset loads the idle level of every pin.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_ff <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign level_out = s_ff.val;

endmodule

`default_nettype wire

// *** src/multi_rail_reset_supervisor.sv ***
// Multi-rail reset supervisor: system reset, watchdog fault and
// per-rail undervoltage outputs, all active low.
// Assumes analog comparators deliver rail flags and a supply-good level.
`timescale 1ns/10ps
`default_nettype none
`include "supervisor_regs.svh"

module multi_rail_reset_supervisor
#(
  parameter int                RAILS      = 6,
  parameter logic [`CNT_W-1:0] RP_DEF_CYC = `CNT_W'(`RP_DEF_CYC),
  parameter logic [`CNT_W-1:0] RP_MAX_CYC = `CNT_W'(`RP_MAX_CYC),
  parameter logic [`CNT_W-1:0] WD_CYC     = `CNT_W'(`WD_CYC)
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Monitored conditions from the analog front end
  input  wire logic [RAILS-1:0]  rail_uv,
  input  wire logic              supply_ok,
  // Control pins
  input  wire logic              manual_reset_n,
  input  wire logic              margin_n,
  input  wire logic              watchdog_kick,
  input  wire logic              watchdog_kick_open,
  input  wire logic              timeout_set,
  // Timeout when timeout_set is low, in clock cycles
  input  wire logic [`CNT_W-1:0] timeout_cycles,
  // Supervisory outputs
  output logic                   sys_reset_n,
  output logic                   watchdog_fault_n,
  output logic      [RAILS-1:0]  rail_out_n
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam logic [`MD_W-1:0]  MD_CYC  = `MD_W'(`MD_CYC);
  localparam logic [`MD_W-1:0]  DB_CYC  = `MD_W'(`DB_CYC);
  localparam logic [`CNT_W-1:0] CNT_ONE = {{(`CNT_W-1){1'b0}}, 1'b1};
  localparam logic [`MD_W-1:0]  MD_ONE  = {{(`MD_W-1){1'b0}}, 1'b1};
  localparam int                SW      = RAILS + 6;
  // Idle levels: pulled-up pins read high, rails read good.
  localparam logic [SW-1:0]     SYNC_INIT = {1'b0, 1'b1, 1'b1, 1'b0,
                                             1'b1, 1'b1, {RAILS{1'b0}}};

  // ----------------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------------
  logic [SW-1:0]    sync_lvl;     // All pins after three stages.
  logic [RAILS-1:0] rail_uv_s;    // Rail undervoltage flags.
  logic             mr_s;         // Manual reset, low active.
  logic             margin_s;     // Margin, low active.
  logic             kick_s;       // Watchdog kick level.
  logic             kick_open_s;  // Kick pin detected floating.
  logic             tset_s;       // Timeout-set strap.
  logic             supply_ok_s;  // Supply above lockout.

  // Pull-ups on manual reset and margin are modelled by their idle
  // reset level; the pins themselves must be tied high when unused.
  input_sync3
  #(
    .W    (SW),
    .INIT (SYNC_INIT)
  )
  u_sync
  (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    ({supply_ok, timeout_set, watchdog_kick_open,
                 watchdog_kick, margin_n, manual_reset_n, rail_uv}),
    .level_out (sync_lvl)
  );

  assign rail_uv_s   = sync_lvl[RAILS-1:0];
  assign mr_s        = sync_lvl[RAILS];
  assign margin_s    = sync_lvl[RAILS+1];
  assign kick_s      = sync_lvl[RAILS+2];
  assign kick_open_s = sync_lvl[RAILS+3];
  assign tset_s      = sync_lvl[RAILS+4];
  assign supply_ok_s = sync_lvl[RAILS+5];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    supervisor_pkg::sup_state_t st;  // Reset sequencer state.
    logic [`CNT_W-1:0] rp_cnt;       // Reset timeout counter.
    logic [`CNT_W-1:0] wd_cnt;       // Watchdog counter.
    logic              wd_fault;     // Watchdog expired, unserviced.
    logic              wd_pend;      // Expired during margin test or its exit delay.
    logic [`MD_W-1:0]  md_cnt;       // Margin-exit delay counter.
    logic [`MD_W-1:0]  db_cnt;       // Manual reset release filter.
    logic              mr_db;        // Debounced manual reset.
    logic              kick_prev;    // Kick level one cycle ago.
    logic              margin_prev;  // Margin level one cycle ago.
    logic              rst_n;        // System reset output.
    logic              wdo_n;        // Watchdog fault output.
    logic [RAILS-1:0]  rail_n;       // Per-rail outputs.
  } sup_regs_t;

  sup_regs_t s_ff;
  sup_regs_t nxt_s;

  logic [`CNT_W-1:0] rp_target;  // Selected reset timeout.
  logic              cause;      // Something demands reset.
  logic              rail_low;   // Any rail below threshold.
  logic              kick_edge;  // Either edge on the kick pin.
  logic              wd_on;      // Watchdog allowed to count.
  logic              margin_on;  // Margin test active.
  logic              margin_end; // First cycle after margin test.

  // Out-of-range requests are clamped so a zero or oversized value
  // cannot stall the sequencer or exceed the longest period.
  assign rp_target = tset_s ? RP_DEF_CYC
                   : (timeout_cycles > RP_MAX_CYC) ? RP_MAX_CYC
                   : (timeout_cycles == '0) ? CNT_ONE
                   : timeout_cycles;

  assign rail_low   = |rail_uv_s;
  assign cause      = rail_low | !s_ff.mr_db;
  assign kick_edge  = kick_s ^ s_ff.kick_prev;
  assign wd_on      = (s_ff.st == supervisor_pkg::ST_RUN)
                    && !kick_open_s;
  assign margin_on  = !margin_s;
  assign margin_end = !s_ff.margin_prev && margin_s;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_s             = s_ff;
    nxt_s.kick_prev   = kick_s;
    nxt_s.margin_prev = margin_s;

    // A press takes effect at once; release must stay high for the
    // filter time, so contact bounce cannot end reset early.
    if (!mr_s)
    begin
      nxt_s.mr_db  = 1'b0;
      nxt_s.db_cnt = '0;
    end
    else if (!s_ff.mr_db)
    begin
      if (s_ff.db_cnt == DB_CYC - MD_ONE)
      begin
        nxt_s.mr_db  = 1'b1;
        nxt_s.db_cnt = '0;
      end
      else
      begin
        nxt_s.db_cnt = s_ff.db_cnt + MD_ONE;
      end
    end
    else
    begin
      nxt_s.db_cnt = '0;
    end

    // Reset sequencer.
    case (s_ff.st)
      supervisor_pkg::ST_LOCKOUT:
      begin
        nxt_s.st = supervisor_pkg::ST_HOLD;
      end
      supervisor_pkg::ST_HOLD:
      begin
        // Stay while any cause remains.
        if (!cause)
        begin
          nxt_s.st     = supervisor_pkg::ST_TIMEOUT;
          nxt_s.rp_cnt = '0;
        end
      end
      supervisor_pkg::ST_TIMEOUT:
      begin
        // A returning cause restarts the full period.
        if (cause)
        begin
          nxt_s.st = supervisor_pkg::ST_HOLD;
        end
        else if (s_ff.rp_cnt >= rp_target - CNT_ONE)
        begin
          nxt_s.st = supervisor_pkg::ST_RUN;
        end
        else
        begin
          nxt_s.rp_cnt = s_ff.rp_cnt + CNT_ONE;
        end
      end
      supervisor_pkg::ST_RUN:
      begin
        if (cause)
        begin
          nxt_s.st = supervisor_pkg::ST_HOLD;
        end
      end
      default:
      begin
        nxt_s.st = supervisor_pkg::ST_LOCKOUT;
      end
    endcase
    if (!supply_ok_s)
    begin
      nxt_s.st = supervisor_pkg::ST_LOCKOUT;
    end

    // Watchdog. It keeps counting through margin test; an expiry then
    // is parked until the margin-exit delay has run out.
    if (!s_ff.mr_db || kick_open_s || rail_low)
    begin
      nxt_s.wd_fault = 1'b0;
      nxt_s.wd_pend  = 1'b0;
    end
    if (!wd_on)
    begin
      nxt_s.wd_cnt = '0;
    end
    else if (kick_edge)
    begin
      nxt_s.wd_cnt   = '0;
      nxt_s.wd_fault = 1'b0;
      nxt_s.wd_pend  = 1'b0;
    end
    else if (s_ff.wd_cnt >= WD_CYC - CNT_ONE)
    begin
      nxt_s.wd_cnt = '0;
      if (margin_on || s_ff.md_cnt != '0)
      begin
        nxt_s.wd_pend = 1'b1;
      end
      else
      begin
        nxt_s.wd_fault = 1'b1;
      end
    end
    else
    begin
      nxt_s.wd_cnt = s_ff.wd_cnt + CNT_ONE;
    end

    // Margin-exit delay.
    if (margin_end && nxt_s.wd_pend)
    begin
      nxt_s.md_cnt = MD_CYC;
    end
    else if (margin_on)
    begin
      nxt_s.md_cnt = '0;
    end
    else if (s_ff.md_cnt != '0)
    begin
      nxt_s.md_cnt = s_ff.md_cnt - MD_ONE;
      if (s_ff.md_cnt == MD_ONE && nxt_s.wd_pend)
      begin
        nxt_s.wd_fault = 1'b1;
        nxt_s.wd_pend  = 1'b0;
      end
    end

    // Outputs, registered. Lockout wins over margin, margin over all.
    if (nxt_s.st == supervisor_pkg::ST_LOCKOUT)
    begin
      nxt_s.rst_n  = 1'b0;
      nxt_s.wdo_n  = 1'b0;
      nxt_s.rail_n = '0;
    end
    else if (margin_on)
    begin
      nxt_s.rst_n  = 1'b1;
      nxt_s.wdo_n  = 1'b1;
      nxt_s.rail_n = '1;
    end
    else
    begin
      nxt_s.rst_n  = (nxt_s.st == supervisor_pkg::ST_RUN);
      nxt_s.wdo_n  = !rail_low && !nxt_s.wd_fault;
      nxt_s.rail_n = ~rail_uv_s;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_ff       <= '0;
      s_ff.st    <= supervisor_pkg::ST_LOCKOUT;
      s_ff.mr_db <= 1'b1;
      s_ff.margin_prev <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign sys_reset_n      = s_ff.rst_n;
  assign watchdog_fault_n = s_ff.wdo_n;
  assign rail_out_n       = s_ff.rail_n;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cause_resets;
    (cause && margin_s) |=> !sys_reset_n;
  endproperty
  a_cause_resets: assert property (p_cause_resets)
    else $error("reset not asserted for a low rail or manual reset");

  property p_release_after_timeout;
    (s_ff.st == supervisor_pkg::ST_TIMEOUT && !cause && supply_ok_s
      && margin_s && s_ff.rp_cnt == rp_target - CNT_ONE)
      |=> sys_reset_n;
  endproperty
  a_release_after_timeout: assert property (p_release_after_timeout)
    else $error("reset not released at end of timeout");

  property p_no_early_release;
    (s_ff.st == supervisor_pkg::ST_TIMEOUT && s_ff.rp_cnt < rp_target
      - CNT_ONE && margin_s && $past(margin_s)) |=> !sys_reset_n;
  endproperty
  a_no_early_release: assert property (p_no_early_release)
    else $error("reset released before timeout ran out");

  property p_rail_wdo;
    (rail_low && margin_s) |=> !watchdog_fault_n;
  endproperty
  a_rail_wdo: assert property (p_rail_wdo)
    else $error("watchdog fault not asserted for a low rail");

  property p_wdo_release;
    (!rail_low && !nxt_s.wd_fault && margin_s && supply_ok_s)
      |=> watchdog_fault_n;
  endproperty
  a_wdo_release: assert property (p_wdo_release)
    else $error("watchdog fault not released after rails recovered");

  property p_wd_expire;
    (wd_on && !kick_edge && s_ff.wd_cnt == WD_CYC - CNT_ONE && margin_s
      && s_ff.md_cnt == '0 && s_ff.mr_db) |=> !watchdog_fault_n;
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("watchdog expiry did not assert fault");

  property p_kick_clears;
    (wd_on && kick_edge && !rail_low && margin_s && supply_ok_s)
      |=> (watchdog_fault_n && s_ff.wd_cnt == '0);
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("kick edge did not service the watchdog");

  property p_wd_idle;
    (s_ff.st != supervisor_pkg::ST_RUN || kick_open_s) |=> s_ff.wd_cnt == '0;
  endproperty
  a_wd_idle: assert property (p_wd_idle)
    else $error("watchdog counted outside normal run");

  property p_margin_high;
    (margin_on && supply_ok_s) |=> (sys_reset_n && watchdog_fault_n
      && rail_out_n == '1);
  endproperty
  a_margin_high: assert property (p_margin_high)
    else $error("outputs not forced high in margin test");

  property p_margin_exit;
    (margin_end && nxt_s.wd_pend) |=> s_ff.md_cnt == MD_CYC;
  endproperty
  a_margin_exit: assert property (p_margin_exit)
    else $error("margin-exit delay not started");

  property p_lockout;
    !supply_ok_s |=> (!sys_reset_n && !watchdog_fault_n
      && rail_out_n == '0);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("outputs not asserted under lockout");

  property p_rail_follow;
    (supply_ok_s && margin_s) |=> rail_out_n == ~$past(rail_uv_s);
  endproperty
  a_rail_follow: assert property (p_rail_follow)
    else $error("rail output does not follow its flag");

  c_release: cover property ($rose(sys_reset_n) && margin_s);
  c_wd_fault: cover property ($fell(watchdog_fault_n) && !rail_low);
  c_md_fire: cover property (s_ff.md_cnt == MD_ONE && s_ff.wd_pend);
  c_lockout_exit: cover property (supply_ok_s && !$past(supply_ok_s));

endmodule

`default_nettype wire

// *** verif/host_model.sv ***
// Host processor model: watches system reset and toggles the kick pin.
// Assumes the bench enables kicking and sets the toggle period.
`timescale 1ns/10ps
`default_nettype none

module host_model
(
  // Clock
  input  wire logic       clk,
  // Supervisor reset and bench control
  input  wire logic       sys_reset_n,
  input  wire logic       kick_on,
  input  wire logic [7:0] kick_period,
  // Kick pin toward the supervisor
  output logic            watchdog_kick
);
  logic [7:0] cnt_ff;         // Cycles since the last toggle.
  logic       kick_ff = 1'b0; // Pin level, known from time zero.

  // A host held in reset cannot service; out of reset with kick_on high it toggles.
  always_ff @(posedge clk)
  begin
    if (!sys_reset_n || !kick_on)
    begin
      cnt_ff <= 8'h00;
    end
    else if (cnt_ff == kick_period)
    begin
      cnt_ff  <= 8'h00;
      kick_ff <= ~kick_ff;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign watchdog_kick = kick_ff;
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the multi-rail reset supervisor.
// Assumes short timing parameters; debounce and margin delay stay full.
`timescale 1ns/10ps
`default_nettype none
`include "supervisor_regs.svh"

module testbench;
  localparam int RP  = 50;   // Default reset timeout, shortened.
  localparam int RPX = 200;  // Longest reset timeout, shortened.
  localparam int WD  = 100;  // Watchdog period, shortened.
  localparam int MD  = 2000; // Margin-exit delay in cycles.
  localparam int DB  = 2000; // Manual release debounce in cycles.
  localparam int LAT = 5;    // Pin change to output, in cycles.

  logic              clk = 1'b0;
  logic              reset_n;
  logic [5:0]        rail_uv;
  logic              supply_ok;
  logic              manual_reset_n;
  logic              margin_n;
  logic              kick_open;
  logic              timeout_set;
  logic [`CNT_W-1:0] timeout_cycles;
  logic              sys_reset_n;
  logic              watchdog_fault_n;
  logic [5:0]        rail_out_n;
  logic              watchdog_kick;
  logic              kick_on;
  int                errors = 0;
  int                n_compared = 0;
  int                n;

  always #25 clk = ~clk;

  multi_rail_reset_supervisor #(.RAILS(6), .RP_DEF_CYC(`CNT_W'(RP)),
    .RP_MAX_CYC(`CNT_W'(RPX)), .WD_CYC(`CNT_W'(WD))) u_dut
  (
    .clk(clk), .reset_n(reset_n), .rail_uv(rail_uv), .supply_ok(supply_ok),
    .manual_reset_n(manual_reset_n), .margin_n(margin_n),
    .watchdog_kick(watchdog_kick), .watchdog_kick_open(kick_open),
    .timeout_set(timeout_set), .timeout_cycles(timeout_cycles),
    .sys_reset_n(sys_reset_n), .watchdog_fault_n(watchdog_fault_n),
    .rail_out_n(rail_out_n)
  );

  host_model u_host
  (
    .clk(clk), .sys_reset_n(sys_reset_n), .kick_on(kick_on),
    .kick_period(8'h28), .watchdog_kick(watchdog_kick)
  );

  // Compares a seen value with the expected one and counts both.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
      begin
        errors++;
        $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
  endtask

  task automatic in_range(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask

  // Inputs move 1 ns after the edge so sampling never races.
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Counts cycles until reset (sel 0) or fault (sel 1) reaches lvl.
  // A limit that runs out is itself a mismatch.
  task automatic wait_out(input int sel, input logic lvl, input int lim);
    logic lvl_now;
    n = 0;
    while (((sel == 0) ? sys_reset_n : watchdog_fault_n) !== lvl && n < lim)
    begin
      tick(1);
      n++;
    end
    lvl_now = (sel == 0) ? sys_reset_n : watchdog_fault_n;
    check(32'(lvl_now), 32'(lvl));
  endtask

  task automatic t_power();
    check({sys_reset_n, watchdog_fault_n, rail_out_n}, 8'h00);
    supply_ok = 1'b1;
    wait_out(0, 1'b1, 200);
    in_range(n, RP + LAT - 1, RP + LAT + 3);
    check(rail_out_n, 6'h3F);
  endtask

  task automatic t_rail();
    rail_uv = 6'h04;
    tick(LAT + 1);
    check({sys_reset_n, watchdog_fault_n, rail_out_n}, 8'h3B);
    rail_uv = 6'h00;
    tick(LAT + 1);
    check({sys_reset_n, watchdog_fault_n, rail_out_n}, 8'h7F);
    wait_out(0, 1'b1, 300);
    in_range(n + LAT + 1, RP + LAT - 1, RP + LAT + 3);
  endtask

  // Programmed timeouts: plain, clamped to the maximum, and zero.
  task automatic t_timeout();
    int set_v[3] = '{120, 500, 0};
    int exp_v[3] = '{120, RPX, 1};
    timeout_set = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      timeout_cycles = `CNT_W'(set_v[i]);
      rail_uv = 6'h01;
      tick(10);
      rail_uv = 6'h00;
      wait_out(0, 1'b1, 400);
      in_range(n, exp_v[i] + LAT - 1, exp_v[i] + LAT + 3);
    end
    timeout_set = 1'b1;
  endtask

  task automatic t_wdog();
    kick_on = 1'b1;
    tick(400);
    check(watchdog_fault_n, 1'b1);
    kick_on = 1'b0;
    wait_out(1, 1'b0, 300);
    in_range(n, WD - 45, WD + LAT + 3);
    kick_on = 1'b1;
    wait_out(1, 1'b1, 60);
    in_range(n, 1, 50);
    kick_on = 1'b0;
    wait_out(1, 1'b0, 300);
    manual_reset_n = 1'b0;
    tick(LAT + 1);
    check({sys_reset_n, watchdog_fault_n}, 2'b01);
    // A bouncing release must restart the debounce count.
    manual_reset_n = 1'b1;
    tick(3);
    manual_reset_n = 1'b0;
    tick(3);
    manual_reset_n = 1'b1;
    wait_out(0, 1'b1, 3000);
    in_range(n, DB + RP, DB + RP + LAT + 6);
    wait_out(1, 1'b0, 300);
    in_range(n, WD - 1, WD + 3);
    kick_on = 1'b1;
    wait_out(1, 1'b1, 60);
  endtask

  task automatic t_margin();
    kick_on = 1'b0;
    margin_n = 1'b0;
    tick(LAT + 1);
    // The watchdog expires inside this span; outputs must not move.
    repeat (150)
    begin
      check({sys_reset_n, watchdog_fault_n, rail_out_n}, 8'hFF);
      tick(1);
    end
    margin_n = 1'b1;
    wait_out(1, 1'b0, 2100);
    in_range(n, MD, MD + LAT + 4);
    kick_on = 1'b1;
    wait_out(1, 1'b1, 60);
    margin_n = 1'b0;
    tick(LAT + 1);
    rail_uv = 6'h3F;
    tick(20);
    check({sys_reset_n, watchdog_fault_n, rail_out_n}, 8'hFF);
    rail_uv = 6'h00;
    tick(LAT + 1);
    margin_n = 1'b1;
    tick(LAT + 1);
    check(sys_reset_n, 1'b0);
    wait_out(0, 1'b1, 200);
  endtask

  task automatic t_open();
    kick_open = 1'b1;
    kick_on = 1'b0;
    tick(300);
    check(watchdog_fault_n, 1'b1);
  endtask

  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence: lockout first, then each scenario in turn.
  initial
  begin
    reset_n = 1'b0;
    rail_uv = 6'h00;
    supply_ok = 1'b0;
    manual_reset_n = 1'b1;
    margin_n = 1'b1;
    kick_open = 1'b0;
    timeout_set = 1'b1;
    timeout_cycles = `CNT_W'(RP);
    kick_on = 1'b1;
    tick(4);
    reset_n = 1'b1;
    tick(10);
    t_power();
    t_rail();
    t_timeout();
    t_wdog();
    t_margin();
    t_open();
    results();
  end

  // Scenarios need about 6000 cycles; cut a hang at 20000.
  initial
  begin
    #1000000;
    errors++;
    results();
  end
endmodule

`default_nettype wire
